// >>> anf_regs.svh
// Offsets, field positions, reset values and timing for the negotiation block
`ifndef ANF_REGS_SVH
`define ANF_REGS_SVH
`define ANF_ADDR_BLS 5'h01
`define ANF_ADDR_PRMS 5'h19
`define ANF_BLS_LINK 2
`define ANF_BLS_ANDONE 5
`define ANF_PRMS_SPD10 6
`define ANF_PRMS_DUPLEX 7
`define ANF_LCW_ACK 14
`define ANF_RST_WORD 16'h0000
`define ANF_CLK_PERIOD_NS 25
`define ANF_TICK_NS 1000
`define ANF_TICK_CYC (`ANF_TICK_NS / `ANF_CLK_PERIOD_NS)
`define ANF_DDET_MIN_US 15
`define ANF_DATA_WIN_US 90
`define ANF_BURST_END_US 200
`define ANF_NLP_MIN_US 5000
`define ANF_NLP_MIN_ERR_US 3800
`define ANF_NLP_MAX_MS 150
`define ANF_LFI_MS 750
`define ANF_LFI_ERR_MS 640
`define ANF_BREAK_MS 1200
`define ANF_LINK_MS 60
`define ANF_US_PER_MS 1000
`endif

// >>> anf_pkg.sv
// Types shared by the negotiation block
package anf_pkg;
	typedef enum logic [2:0] {ARB_ABILITY, ARB_ACK, ARB_CHECK, ARB_GOOD, ARB_BREAK} anf_arb_t;
	typedef enum logic [1:0] {RX_IDLE, RX_CLK, RX_DAT} anf_rx_t;
endpackage

// >>> anf_arbiter.sv
// Pulse burst receive, consistency matching, arbitration timers and status
// Functional notes
// (RULE1) As built, alternating ABAB groups still reach acknowledge and set ack bit.
// (RULE2) Gap between bursts above 150ms counts as exceeding the maximum timer; checked only in the compliant build, not as built.
// (RULE3) Minimum spacing timer is 3.8ms as built; compliant value is 5ms.
// (RULE4) Four bursts closer than the minimum spacing never reach acknowledge, in either build.
// (RULE5) Data detect minimum timer restarts from zero when a pulse comes early.
// (RULE6) Extra pulse after a clock pulse is kept, spoiling that burst's acknowledge.
// (RULE7) Link-fail-inhibit is 640ms as built; compliant value is 750ms.
// (RULE8) Link good check stops bursts, fails link, restarts after both timers.
// (RULE9) Valid signals after selection give good link well within 250ms.
// (RULE10) Link-fail-inhibit outlasts every technology's link-up time.
// (RULE11) Partner spaces bursts at least 8ms apart, typically near 16ms.
// (RULE12) Partner keeps data pulse to next clock pulse about 78us or less.
// (RULE13) Partner repeats the same burst continuously, not in gapped groups.
// (RULE14) Software waits about 3 seconds for negotiation before judging.
// (RULE15) Software checks status bit 5, then rereads status for link bit 2.
// (RULE16) Register 19h bits 7 and 6 give resolved duplex and 10 Mb/s speed.
// (RULE17) Link status bit 2 latches failure; reading twice gives current state.
// (RULE18) All timers count device clock ticks against parameter terminal counts.
// (RULE19) A differing code word clears matching progress and restarts matching; as built, a word equal to the one two bursts back still advances.
`include "anf_regs.svh"
module anf_arbiter import anf_pkg::*; #(
	parameter bit AS_BUILT = 1'b1,
	parameter logic [7:0] LOCAL_ABILITY = 8'h0F,
	parameter int TICK_CYC = `ANF_TICK_CYC,
	parameter int BURST_END_T = `ANF_BURST_END_US,
	parameter int NLP_MIN_T = AS_BUILT ? `ANF_NLP_MIN_ERR_US : `ANF_NLP_MIN_US,
	parameter int NLP_MAX_T = `ANF_NLP_MAX_MS * `ANF_US_PER_MS,
	parameter int LFI_T = (AS_BUILT ? `ANF_LFI_ERR_MS : `ANF_LFI_MS) * `ANF_US_PER_MS,
	parameter int BREAK_T = `ANF_BREAK_MS * `ANF_US_PER_MS,
	parameter int LINK_T = `ANF_LINK_MS * `ANF_US_PER_MS
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Cable side
	input wire logic rx_pulse,
	input wire logic link_ok,
	output logic flp_tx_en,
	// Status read port
	input wire logic rd_en,
	input wire logic [4:0] rd_addr,
	output logic [15:0] rd_data,
	output logic ack_bit
);
	localparam int DDET_MIN_T = `ANF_DDET_MIN_US;
	localparam int DATA_WIN_T = `ANF_DATA_WIN_US;
	// Link code words compare without the acknowledge bit
	function automatic logic same_word(input logic [15:0] a, input logic [15:0] b);
		same_word = ((a ^ b) & ~(16'h0001 << `ANF_LCW_ACK)) == 16'h0000;
	endfunction
	// Returns {duplex, speed_10}; highest common ability wins
	function automatic logic [1:0] resolve(input logic [15:0] w);
		logic [7:0] c;
		c = w[12:5] & LOCAL_ABILITY;
		resolve = c[3] ? 2'h2 : (c[2] ? 2'h0 : (c[1] ? 2'h3 : 2'h1));
	endfunction
	// Synchroniser and 1us tick
	logic s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next, pulse;
	logic [5:0] tdiv_reg, tdiv_next;
	logic tick_reg, tick_next;
	always_comb begin
		lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
		tick_next = (tdiv_reg == 6'(TICK_CYC - 1));
		tdiv_next = tick_next ? 6'h00 : tdiv_reg + 6'h01;
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			lvl_reg <= 1'b0;
			tdiv_reg <= 6'h00;
			tick_reg <= 1'b0;
		end else begin
			s1_reg <= rx_pulse;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= lvl_next;
			tdiv_reg <= tdiv_next;
			tick_reg <= tick_next;
		end
	end
	assign pulse = lvl_next & ~lvl_reg;
	// Burst receiver
	anf_rx_t rx_reg, rx_next;
	logic [15:0] gap_reg, gap_next, word_reg, word_next;
	logic [4:0] bits_reg, bits_next;
	logic bad_reg, bad_next, done_reg, done_next;
	logic [17:0] sp_reg, sp_next;
	always_comb begin
		rx_next = rx_reg;
		word_next = word_reg;
		bits_next = bits_reg;
		bad_next = bad_reg;
		done_next = 1'b0;
		gap_next = gap_reg;
		if (tick_reg && gap_reg != 16'hFFFF) begin
			gap_next = gap_reg + 16'h0001;
		end
		// Cleared only after the arbiter has judged it, so spacing runs end to end
		sp_next = sp_reg;
		if (done_reg) begin
			sp_next = 18'h00000; // RULE3
		end else if (tick_reg && sp_reg != 18'h3FFFF) begin
			sp_next = sp_reg + 18'h00001;
		end
		if (pulse) begin
			gap_next = 16'h0000;
			case (rx_reg)
				RX_IDLE: begin
					rx_next = RX_CLK;
					bits_next = 5'h00;
					bad_next = 1'b0;
				end
				RX_CLK: begin
					if (gap_reg < 16'(DDET_MIN_T)) begin
						bad_next = 1'b1; // RULE5 RULE6
					end else begin
						word_next = {(gap_reg < 16'(DATA_WIN_T)), word_reg[15:1]};
						rx_next = (gap_reg < 16'(DATA_WIN_T)) ? RX_DAT : RX_CLK;
						if (bits_reg != 5'h1F) begin
							bits_next = bits_reg + 5'h01;
						end
					end
				end
				RX_DAT: rx_next = RX_CLK;
				default: rx_next = RX_IDLE;
			endcase
		end else if (rx_reg != RX_IDLE && tick_reg && gap_reg >= 16'(BURST_END_T)) begin
			rx_next = RX_IDLE;
			done_next = 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rx_reg <= RX_IDLE;
			gap_reg <= 16'hFFFF;
			word_reg <= `ANF_RST_WORD;
			bits_reg <= 5'h00;
			bad_reg <= 1'b0;
			done_reg <= 1'b0;
			sp_reg <= 18'h3FFFF;
		end else begin
			rx_reg <= rx_next;
			gap_reg <= gap_next;
			word_reg <= word_next;
			bits_reg <= bits_next;
			bad_reg <= bad_next;
			done_reg <= done_next;
			sp_reg <= sp_next;
		end
	end
	// Arbitration, timers and status registers
	anf_arb_t st_reg, st_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [15:0] w1_reg, w1_next, w2_reg, w2_next, rd_reg, rd_next;
	logic [21:0] tmr_reg, tmr_next;
	logic flp_reg, flp_next, ack_reg, ack_next, good_reg, good_next, done_an_reg, done_an_next;
	logic dup_reg, dup_next, spd_reg, spd_next, latch_reg, latch_next;
	logic burst_ok, matched, too_close, too_far, held;
	logic [1:0] res;
	always_comb begin
		burst_ok = done_reg && !bad_reg && bits_reg == 5'h10; // RULE6
		too_close = sp_reg < 18'(NLP_MIN_T); // RULE3 RULE4
		too_far = !AS_BUILT && sp_reg > 18'(NLP_MAX_T); // RULE2
		matched = same_word(word_reg, w1_reg) || (AS_BUILT && same_word(word_reg, w2_reg)); // RULE1
		res = resolve(word_reg);
		st_next = st_reg;
		cnt_next = cnt_reg;
		w1_next = w1_reg;
		w2_next = w2_reg;
		flp_next = flp_reg;
		ack_next = ack_reg;
		good_next = good_reg;
		done_an_next = done_an_reg;
		dup_next = dup_reg;
		spd_next = spd_reg;
		tmr_next = tick_reg ? tmr_reg + 22'h000001 : tmr_reg; // RULE18
		if (done_reg) begin
			if (!burst_ok || too_close) begin
				cnt_next = 3'h0; // RULE4 RULE6
			end else if (too_far || !matched) begin
				cnt_next = 3'h1; // RULE19 RULE2
				w1_next = word_reg;
				w2_next = w1_reg;
			end else if (cnt_reg != 3'h4) begin
				cnt_next = cnt_reg + 3'h1;
				w2_next = w1_reg;
				w1_next = word_reg;
			end
		end
		case (st_reg)
			ARB_ABILITY: begin
				if (cnt_next == 3'h4) begin
					st_next = ARB_ACK; // RULE1 RULE4
					ack_next = 1'b1;
				end
			end
			ARB_ACK: begin
				if (burst_ok && matched && word_reg[`ANF_LCW_ACK]) begin
					st_next = ARB_CHECK;
					tmr_next = 22'h000000;
					flp_next = 1'b0; // RULE8
					good_next = 1'b0;
					dup_next = res[1]; // RULE16
					spd_next = res[0];
				end
			end
			ARB_CHECK: begin
				if (link_ok) begin
					st_next = ARB_GOOD; // RULE9
					good_next = 1'b1;
					done_an_next = 1'b1;
				end else if (tick_reg && tmr_reg >= 22'(LFI_T - 1)) begin
					st_next = ARB_BREAK; // RULE7 RULE10
					tmr_next = 22'h000000;
				end
			end
			ARB_GOOD: begin
				if (!link_ok) begin
					st_next = ARB_BREAK;
					tmr_next = 22'h000000;
					good_next = 1'b0;
					done_an_next = 1'b0;
					ack_next = 1'b0;
				end
			end
			ARB_BREAK: begin
				if (tick_reg && tmr_reg >= 22'(BREAK_T - 1) && tmr_reg >= 22'(LINK_T - 1)) begin
					st_next = ARB_ABILITY; // RULE8
					flp_next = 1'b1;
					ack_next = 1'b0;
					cnt_next = 3'h0;
				end
			end
			default: st_next = ARB_ABILITY;
		endcase
		// Failure seen in the read cycle still latches low
		held = latch_reg & good_next;
		latch_next = held; // RULE17
		rd_next = rd_reg;
		if (rd_en) begin
			rd_next = 16'h0000;
			if (rd_addr == `ANF_ADDR_BLS) begin
				rd_next[`ANF_BLS_LINK] = latch_reg;
				rd_next[`ANF_BLS_ANDONE] = done_an_reg;
				latch_next = good_next; // RULE17
			end else if (rd_addr == `ANF_ADDR_PRMS) begin
				rd_next[`ANF_PRMS_DUPLEX] = dup_reg; // RULE16
				rd_next[`ANF_PRMS_SPD10] = spd_reg;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_reg <= ARB_ABILITY;
			cnt_reg <= 3'h0;
			w1_reg <= `ANF_RST_WORD;
			w2_reg <= `ANF_RST_WORD;
			tmr_reg <= 22'h000000;
			flp_reg <= 1'b1;
			ack_reg <= 1'b0;
			good_reg <= 1'b0;
			done_an_reg <= 1'b0;
			dup_reg <= 1'b0;
			spd_reg <= 1'b0;
			latch_reg <= 1'b0;
			rd_reg <= 16'h0000;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			w1_reg <= w1_next;
			w2_reg <= w2_next;
			tmr_reg <= tmr_next;
			flp_reg <= flp_next;
			ack_reg <= ack_next;
			good_reg <= good_next;
			done_an_reg <= done_an_next;
			dup_reg <= dup_next;
			spd_reg <= spd_next;
			latch_reg <= latch_next;
			rd_reg <= rd_next;
		end
	end
	assign flp_tx_en = flp_reg;
	assign ack_bit = ack_reg;
	assign rd_data = rd_reg;
	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_enter_check;
		st_reg == ARB_ACK ##1 st_reg == ARB_CHECK;
	endsequence
	property p_ack_after_four;
		$rose(ack_reg) |-> $past(done_reg) && $past(cnt_reg) == 3'h3;
	endproperty
	a_ack_after_four: assert property (p_ack_after_four) else $error("ack without four bursts"); // RULE4
	property p_close_rejected;
		done_reg && sp_reg < 18'(NLP_MIN_T) |=> cnt_reg == 3'h0;
	endproperty
	a_close_rejected: assert property (p_close_rejected) else $error("close burst kept"); // RULE3
	property p_far_restarts;
		burst_ok && !AS_BUILT && sp_reg > 18'(NLP_MAX_T) && sp_reg >= 18'(NLP_MIN_T) |=> cnt_reg == 3'h1;
	endproperty
	a_far_restarts: assert property (p_far_restarts) else $error("long gap not restarting"); // RULE2
	property p_bad_burst;
		done_reg && bad_reg |=> cnt_reg == 3'h0 && !$rose(ack_reg);
	endproperty
	a_bad_burst: assert property (p_bad_burst) else $error("spoiled burst counted"); // RULE6
	property p_early_pulse;
		pulse && rx_reg == RX_CLK && gap_reg < 16'(DDET_MIN_T) |=> bad_reg && gap_reg == 16'h0000;
	endproperty
	a_early_pulse: assert property (p_early_pulse) else $error("early pulse not flagged"); // RULE5
	property p_check_silent;
		s_enter_check |-> !flp_reg && !good_reg;
	endproperty
	a_check_silent: assert property (p_check_silent) else $error("bursts or link in check"); // RULE8
	property p_inhibit_len;
		st_reg == ARB_CHECK ##1 st_reg == ARB_BREAK |-> $past(tmr_reg) >= 22'(LFI_T - 1);
	endproperty
	a_inhibit_len: assert property (p_inhibit_len) else $error("inhibit expired early"); // RULE7
	property p_link_up;
		st_reg == ARB_CHECK && link_ok |=> st_reg == ARB_GOOD && good_reg && done_an_reg;
	endproperty
	a_link_up: assert property (p_link_up) else $error("link not good after valid signal"); // RULE9
	property p_latch_low;
		$fell(good_reg) |-> !latch_reg;
	endproperty
	a_latch_low: assert property (p_latch_low) else $error("link latch missed failure"); // RULE17
	property p_mode_read;
		rd_en && rd_addr == `ANF_ADDR_PRMS |=> rd_reg[7:6] == {$past(dup_reg), $past(spd_reg)};
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("mode bits wrong"); // RULE16
	property p_restart_flp;
		st_reg == ARB_BREAK ##1 st_reg == ARB_ABILITY |-> flp_reg && !ack_reg;
	endproperty
	a_restart_flp: assert property (p_restart_flp) else $error("bursts not restarted"); // RULE8
endmodule // anf_arbiter

// >>> anf_partner.sv
// Remote link partner model sending pulse bursts
module anf_partner (
	// Link timing
	input wire logic link_clk,
	// Cable
	output logic rx_pulse
);
	timeunit 1ns;
	timeprecision 1ps;

	// Line idles low between pulses and between bursts
	initial rx_pulse = 1'b0;

	task automatic pulse();
		rx_pulse = 1'b1;
		@(posedge link_clk);
		rx_pulse = 1'b0;
	endtask

	// Bits LSB first; data to next clock is 25 link clocks, well inside the limit
	task automatic send(input logic [15:0] w, input bit spoil);
		for (int i = 0; i < 17; i++) begin
			pulse();
			if (i < 16) begin
				// Noise pulse shortly after a clock pulse
				if (spoil && i == 3) begin
					repeat (2) @(posedge link_clk);
					pulse();
				end
				repeat (24) @(posedge link_clk);
				if (w[i]) pulse();
				else @(posedge link_clk);
				repeat (24) @(posedge link_clk);
			end
		end
	endtask
endmodule // anf_partner

// >>> anf_arbiter_tb.sv
// Self-checking bench for the negotiation arbiter
`include "anf_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module anf_arbiter_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TC = 4;
	localparam int BRK = 40;
	logic ref_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n = 1'b0;
	logic link_ok = 1'b0;
	logic rd_en = 1'b0;
	logic [4:0] rd_addr = 5'h00;
	logic rx_pulse;
	logic flp_tx_en;
	logic ack_bit;
	logic ack_c;
	logic [15:0] rd_data;
	logic [15:0] rv;
	logic [15:0] w;
	logic [31:0] seed = 32'h0000002A;
	int mismatches = 0;
	int total_checks = 0;

	always #12.5 ref_clk = ~ref_clk;
	// Pulse timing runs off an unrelated 200 ns clock
	always #100 link_clk = ~link_clk;

	anf_partner u_lp (.link_clk(link_clk), .rx_pulse(rx_pulse));

	// Shortened terminal counts keep the run short
	anf_arbiter #(.TICK_CYC(TC), .NLP_MIN_T(300), .LFI_T(50), .BREAK_T(BRK), .LINK_T(20)) dut (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.rx_pulse(rx_pulse),
		.link_ok(link_ok),
		.flp_tx_en(flp_tx_en),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.ack_bit(ack_bit)
	);

	// Compliant build with a short maximum spacing: every burst restarts matching
	anf_arbiter #(.AS_BUILT(1'b0), .TICK_CYC(TC), .NLP_MIN_T(300), .NLP_MAX_T(1000)) dut_compliant (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.rx_pulse(rx_pulse),
		.link_ok(link_ok),
		.flp_tx_en(),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(),
		.ack_bit(ack_c)
	);

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Local side offers all four, so the partner's best one wins; {duplex, speed10}
	function automatic logic [1:0] res(input logic [15:0] v);
		if (v[8]) return 2'b10;
		if (v[7]) return 2'b00;
		if (v[6]) return 2'b11;
		return 2'b01;
	endfunction

	task automatic rd(input logic [4:0] a);
		@(posedge ref_clk);
		#2 rd_en = 1'b1;
		rd_addr = a;
		@(posedge ref_clk);
		#2 rd_en = 1'b0;
		@(posedge ref_clk);
		#2 rv = rd_data;
	endtask

	// Burst then a gap far beyond the minimum spacing
	task automatic burst(input logic [15:0] v, input bit spoil);
		u_lp.send(v, spoil);
		repeat (250) @(posedge link_clk);
	endtask

	task automatic wrap_up();
		if (mismatches == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge ref_clk);
		mismatches++;
		wrap_up();
	end

	initial begin
		int n;
		repeat (16) @(posedge ref_clk);
		#2 rst_n = 1'b1;
		`CHK("flp_tx_en", 1'b1, flp_tx_en);
		`CHK("ack_bit", 1'b0, ack_bit);
		rd(5'h1F);
		`CHK("unmapped", 16'h0000, rv);
		rd(`ANF_ADDR_BLS);
		`CHK("link", 1'b0, rv[`ANF_BLS_LINK]);
		`CHK("an_done", 1'b0, rv[`ANF_BLS_ANDONE]);
		w = 16'(xs());
		// Force selector 1 and at least one common ability, ack bit clear
		w = (w & 16'hBFE0) | 16'h0021;
		burst(w, 1'b1);
		repeat (3) burst(w, 1'b0);
		`CHK("ack_bit", 1'b0, ack_bit);
		burst(w, 1'b0);
		`CHK("ack_bit", 1'b1, ack_bit);
		`CHK("ack_c", 1'b0, ack_c);
		@(posedge ref_clk);
		#2 link_ok = 1'b1;
		burst(w | 16'h4000, 1'b0);
		`CHK("flp_tx_en", 1'b0, flp_tx_en);
		// Scaled settle time before software judges the outcome
		repeat (30 * TC) @(posedge ref_clk);
		rd(`ANF_ADDR_BLS);
		rd(`ANF_ADDR_BLS);
		`CHK("link", 1'b1, rv[`ANF_BLS_LINK]);
		`CHK("an_done", 1'b1, rv[`ANF_BLS_ANDONE]);
		rd(`ANF_ADDR_PRMS);
		`CHK("resolved", res(w), rv[7:6]);
		@(posedge ref_clk);
		#2 link_ok = 1'b0;
		rd(`ANF_ADDR_BLS);
		`CHK("link", 1'b0, rv[`ANF_BLS_LINK]);
		// Both timers must run out before bursts resume
		repeat ((BRK - 10) * TC) @(posedge ref_clk);
		`CHK("flp_tx_en", 1'b0, flp_tx_en);
		for (n = 0; n < 40 * TC && flp_tx_en !== 1'b1; n++) @(posedge ref_clk);
		#2;
		`CHK("flp_tx_en", 1'b1, flp_tx_en);
		`CHK("ack_bit", 1'b0, ack_bit);
		wrap_up();
	end
endmodule // anf_arbiter_tb
